// >>> design/sif_formatter.sv
// serial audio input formatter: deframes i2s, left- and right-justified words
// assumes bit_clock, frame_clock and serial_data are synchronous inputs whose
// rate is well below clk_sys, and that the configuration holds while enabled
//
// Summary of operation
// - three formats, widths 16, 18, 20, 24
// - right-justified: left high, msb delayed
// - right-justified lsb ends at frame change
// - reset default i2s, msb one clock late
// - i2s: left while frame clock low
// - left-justified: left high, no delay
// - sample data, frame on bit rising edge
// - biphase clock divided from oversampling clock
// - divider follows 384 or 256 ratio
`timescale 1ns/1ns
`default_nettype none
module sif_formatter
	import sif_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic enable,
	input wire logic [1:0] format_sel,
	input wire logic [1:0] width_sel,
	input wire logic ratio_384,
	input wire logic bit_clock,
	input wire logic frame_clock,
	input wire logic serial_data,
	input wire logic oversampling_clock,
	output logic [23:0] sample_data,
	output logic sample_left,
	output logic sample_valid,
	output logic frame_error,
	output logic [1:0] format_active,
	output logic biphase_tick
);

	sif_state_t state;
	logic bclk_prev;
	logic frame_s;
	logic [1:0] fmt_act;
	logic [1:0] wid_act;
	logic [5:0] bit_idx;
	logic [5:0] got;
	logic [23:0] shift;
	logic chan_left;

	// bit clock rising edge and frame clock change seen at that edge
	wire bclk_rise = bit_clock & ~bclk_prev;
	wire edge_lr = bclk_rise & (frame_clock != frame_s);
	wire running = enable & ((state == SIF_RUN) | edge_lr);

	// settings that apply to the bit being sampled now
	wire [1:0] fmt_now = edge_lr ? format_sel : fmt_act;
	wire [1:0] wid_code_now = edge_lr ? width_sel : wid_act;
	wire [5:0] wid_now = sif_width(wid_code_now);
	wire [5:0] dly_now = sif_delay(fmt_now, wid_code_now);
	wire [5:0] got_now = edge_lr ? 6'h00 : got;
	wire [5:0] idx_now = edge_lr ? 6'h00 : ((bit_idx == IDX_MAX) ? IDX_MAX : bit_idx + 6'h01);

	// take a bit once the msb delay has run out and until the word is full
	wire take_bit = bclk_rise & running & (idx_now >= dly_now) & (got_now < wid_now);
	wire word_done = take_bit & (got_now == wid_now - 6'h01);
	wire [23:0] word_raw = {shift[22:0], serial_data};
	wire [5:0] align_amt = SAMPLE_BITS - wid_now;

	// channel of the half starting now: i2s (and spare code 3) puts left on the low level
	wire i2s_now = (fmt_now != FMT_LJ) & (fmt_now != FMT_RJ);
	wire next_left = i2s_now ? ~frame_clock : frame_clock;

	// a change that cuts off a word in progress
	wire cut_short = edge_lr & enable & (state == SIF_RUN) & (got != 6'h00)
		& (got < sif_width(wid_act));

	// edge detect and frame clock sample register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			bclk_prev <= 1'b0;
			frame_s <= 1'b0;
		end else begin
			bclk_prev <= bit_clock;
			if (bclk_rise) begin
				frame_s <= frame_clock;
			end
		end
	end

	// capture state: wait for the first frame change after enable
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state <= SIF_WAIT;
		end else begin
			case (state)
				SIF_WAIT: if (enable && edge_lr) state <= SIF_RUN;
				SIF_RUN: if (!enable) state <= SIF_WAIT;
				default: state <= SIF_WAIT;
			endcase
		end
	end

	// configuration latched only at a frame clock change
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			fmt_act <= FMT_I2S;
			wid_act <= WID_24;
			chan_left <= 1'b0;
		end else if (edge_lr) begin
			fmt_act <= format_sel;
			wid_act <= width_sel;
			chan_left <= next_left;
		end
	end

	// bit position within the channel half and bits taken so far
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			bit_idx <= 6'h00;
			got <= 6'h00;
		end else if (!enable) begin
			bit_idx <= 6'h00;
			got <= 6'h00;
		end else if (bclk_rise) begin
			bit_idx <= idx_now;
			got <= take_bit ? got_now + 6'h01 : got_now;
		end
	end

	// shift register, msb first
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			shift <= 24'h000000;
		end else if (take_bit) begin
			shift <= word_raw;
		end
	end

	// finished word, msb aligned to bit 23 with zero fill below
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sample_data <= 24'h000000;
			sample_left <= 1'b0;
			sample_valid <= 1'b0;
			frame_error <= 1'b0;
		end else begin
			sample_valid <= word_done;
			frame_error <= cut_short;
			if (word_done) begin
				sample_data <= word_raw << align_amt;
				sample_left <= edge_lr ? next_left : chan_left;
			end
		end
	end

	assign format_active = fmt_act;

	// biphase clock enable from the oversampling clock
	sif_osclk_div u_div (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.oversampling_clock(oversampling_clock),
		.ratio_384(ratio_384),
		.biphase_tick(biphase_tick)
	);

	// helper: a frame change has been seen since reset
	logic lr_seen;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			lr_seen <= 1'b0;
		end else if (edge_lr) begin
			lr_seen <= 1'b1;
		end
	end

	chk_reset_i2s: assert property (@(posedge clk_sys) disable iff (!resetn)
		!lr_seen |-> (fmt_act == FMT_I2S))
		else $error("format is not i2s before first frame change");

	chk_cfg_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
		(fmt_act != $past(fmt_act) || wid_act != $past(wid_act)) |-> $past(edge_lr))
		else $error("configuration changed away from frame change");

	chk_i2s_delay: assert property (@(posedge clk_sys) disable iff (!resetn)
		(edge_lr && i2s_now) |-> !take_bit)
		else $error("i2s msb taken without one bit delay");

	chk_lj_nodelay: assert property (@(posedge clk_sys) disable iff (!resetn)
		(edge_lr && enable && fmt_now == FMT_LJ) |-> take_bit)
		else $error("left-justified msb not taken at frame change");

	chk_rj_delay: assert property (@(posedge clk_sys) disable iff (!resetn)
		(take_bit && fmt_now == FMT_RJ && got_now == 6'h00) |-> (idx_now == BITS_PER_HALF - wid_now))
		else $error("right-justified msb at wrong position");

	chk_rj_lsb: assert property (@(posedge clk_sys) disable iff (!resetn)
		(sample_valid && fmt_act == FMT_RJ) |-> ($past(idx_now) == BITS_PER_HALF - 6'h01))
		else $error("right-justified lsb not last before frame change");

	chk_word_len: assert property (@(posedge clk_sys) disable iff (!resetn)
		sample_valid |-> ($past(got_now) == $past(wid_now) - 6'h01))
		else $error("word length differs from selected width");

	chk_channel: assert property (@(posedge clk_sys) disable iff (!resetn)
		edge_lr |=> (chan_left == ($past(i2s_now) ^ $past(frame_clock))))
		else $error("channel polarity wrong for format");

	chk_sample_edge: assert property (@(posedge clk_sys) disable iff (!resetn)
		take_bit |=> (bclk_prev && shift[0] == $past(serial_data)))
		else $error("data bit not taken on bit clock rise");

	chk_valid_single: assert property (@(posedge clk_sys) disable iff (!resetn)
		sample_valid |=> !sample_valid)
		else $error("two words back to back in one half");

	chk_error_alone: assert property (@(posedge clk_sys) disable iff (!resetn)
		frame_error |-> !sample_valid)
		else $error("cut word also reported as valid");

	chk_word_stands: assert property (@(posedge clk_sys) disable iff (!resetn)
		!sample_valid |-> ($stable(sample_data) && $stable(sample_left)))
		else $error("finished word changed without a valid pulse");

endmodule : sif_formatter
`default_nettype wire

// >>> design/sif_osclk_div.sv
// oversampling clock divider producing the biphase clock enable
// assumes oversampling_clock is a synchronous input far slower than clk_sys
`timescale 1ns/1ns
`default_nettype none
module sif_osclk_div
	import sif_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic oversampling_clock,
	input wire logic ratio_384,
	output logic biphase_tick
);

	logic os_prev;
	logic [1:0] cnt;
	logic [1:0] cnt_last;

	// edge detect and terminal count for the selected ratio
	wire os_rise = oversampling_clock & ~os_prev;
	assign cnt_last = ratio_384 ? DIV_LAST_384 : DIV_LAST_256;
	wire at_last = (cnt >= cnt_last);

	// count oversampling edges, one tick per wrap
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			os_prev <= 1'b0;
			cnt <= 2'h0;
			biphase_tick <= 1'b0;
		end else begin
			os_prev <= oversampling_clock;
			biphase_tick <= os_rise & at_last;
			if (os_rise) begin
				cnt <= at_last ? 2'h0 : cnt + 2'h1;
			end
		end
	end

	chk_div_ratio: assert property (@(posedge clk_sys) disable iff (!resetn)
		(os_rise && cnt == cnt_last) |=> (biphase_tick && cnt == 2'h0))
		else $error("biphase tick missing at divider wrap");

	chk_div_only: assert property (@(posedge clk_sys) disable iff (!resetn)
		biphase_tick |-> $past(os_rise))
		else $error("biphase tick without oversampling edge");

endmodule : sif_osclk_div
`default_nettype wire

// >>> design/sif_pkg.sv
// serial audio input formatter: shared constants, codes and decode functions
// assumes one system clock; every pin arrives synchronous to it
package sif_pkg;

	// format selection codes; zero is the reset default
	localparam logic [1:0] FMT_I2S = 2'h0;
	localparam logic [1:0] FMT_LJ = 2'h1;
	localparam logic [1:0] FMT_RJ = 2'h2;

	// word width selection codes
	localparam logic [1:0] WID_16 = 2'h0;
	localparam logic [1:0] WID_18 = 2'h1;
	localparam logic [1:0] WID_20 = 2'h2;
	localparam logic [1:0] WID_24 = 2'h3;

	// frame geometry: 64 bit clocks per frame, 32 per channel half
	localparam logic [5:0] BITS_PER_HALF = 6'h20;
	localparam logic [5:0] SAMPLE_BITS = 6'h18;
	localparam logic [5:0] IDX_MAX = 6'h3f;
	localparam logic [5:0] I2S_DELAY = 6'h01;
	localparam logic [5:0] LJ_DELAY = 6'h00;

	// oversampling edges per biphase tick: 384/128 and 256/128 times frame rate
	localparam logic [1:0] DIV_LAST_384 = 2'h2;
	localparam logic [1:0] DIV_LAST_256 = 2'h1;

	// capture state
	typedef enum logic {SIF_WAIT, SIF_RUN} sif_state_t;

	// word width in bits for a width code
	function automatic logic [5:0] sif_width(input logic [1:0] code);
		case (code)
			WID_16: sif_width = 6'h10;
			WID_18: sif_width = 6'h12;
			WID_20: sif_width = 6'h14;
			default: sif_width = 6'h18;
		endcase
	endfunction : sif_width

	// bit clocks from the frame clock change to the msb
	function automatic logic [5:0] sif_delay(input logic [1:0] fmt, input logic [1:0] code);
		case (fmt)
			FMT_LJ: sif_delay = LJ_DELAY;
			FMT_RJ: sif_delay = BITS_PER_HALF - sif_width(code);
			default: sif_delay = I2S_DELAY;
		endcase
	endfunction : sif_delay

endpackage : sif_pkg

// >>> dv/sif_formatter_tb_top.sv
// self-checking bench for the serial audio input formatter
// assumes sif_pkg, sif_formatter and sif_source are compiled before it
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
	$display("unexpected %s expected %0h seen %0h", what, exp, got); end end
module sif_formatter_tb_top
	import sif_pkg::*;
	;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic enable = 1'b0;
	logic [1:0] format_sel = FMT_I2S;
	logic [1:0] width_sel = WID_16;
	logic ratio_384 = 1'b1;
	logic oversampling_clock = 1'b0;
	wire bit_clock;
	wire frame_clock;
	wire serial_data;
	logic [23:0] sample_data;
	logic sample_left, sample_valid, frame_error, biphase_tick;
	logic [1:0] format_active;
	logic [25:0] exp_q[$];
	logic [25:0] note;
	logic lvl = 1'b0;
	logic cut = 1'b0;
	logic tick_exp = 1'b0;
	logic os_last = 1'b0;
	int os_cnt = 0;
	int comparisons = 0;
	int n_fail = 0;

	always #50 clk_sys = ~clk_sys;

	sif_formatter DUT (.clk_sys(clk_sys), .resetn(resetn), .enable(enable),
		.format_sel(format_sel), .width_sel(width_sel), .ratio_384(ratio_384),
		.bit_clock(bit_clock), .frame_clock(frame_clock), .serial_data(serial_data),
		.oversampling_clock(oversampling_clock), .sample_data(sample_data),
		.sample_left(sample_left), .sample_valid(sample_valid), .frame_error(frame_error),
		.format_active(format_active), .biphase_tick(biphase_tick));
	sif_source src (.clk_sys(clk_sys), .bit_clock(bit_clock), .frame_clock(frame_clock),
		.serial_data(serial_data));

	task automatic results();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results

	// one half frame: note the expected word or cut, then send it
	task automatic half(input logic [1:0] f, input logic [1:0] wc, input int nbits);
		int w;
		int d;
		logic [23:0] word;
		w = (wc == WID_24) ? 24 : 16 + 2 * wc;
		d = (f == FMT_LJ) ? 0 : (f == FMT_RJ) ? 32 - w : 1;
		word = 24'($urandom()) & ((24'h1 << w) - 24'h1);
		lvl = ~lvl;
		format_sel = f;
		width_sel = wc;
		if (cut) exp_q.push_back(26'h2000000);
		cut = enable && nbits < d + w;
		if (enable && !cut) exp_q.push_back({1'b0, (f == FMT_LJ || f == FMT_RJ) ? lvl : ~lvl,
			word << (24 - w)});
		src.send_half(lvl, word, d, w, nbits);
		if (enable) `CHK("format_active", f, format_active)
	endtask : half

	// outputs against the oldest note, divider against its own model
	always @(posedge clk_sys) begin
		if (resetn) begin
			`CHK("biphase_tick", tick_exp, biphase_tick)
			if (sample_valid === 1'b1 || frame_error === 1'b1) begin
				note = (exp_q.size() == 0) ? {~frame_error, 25'h0} : exp_q.pop_front();
				`CHK("frame_error", note[25], frame_error)
				if (!note[25]) begin
					`CHK("sample_data", note[23:0], sample_data)
					`CHK("sample_left", note[24], sample_left)
				end
			end
		end
		tick_exp = 1'b0;
		if (resetn && oversampling_clock && !os_last) begin
			os_cnt++;
			if (os_cnt == (ratio_384 ? 3 : 2)) begin
				tick_exp = 1'b1;
				os_cnt = 0;
			end
		end
		os_last = oversampling_clock & resetn;
	end

	// random oversampling levels; the ratio flips only between ticks
	always @(negedge clk_sys) begin
		if (resetn) begin
			oversampling_clock <= 1'($urandom_range(1));
			if (os_cnt == 0 && $urandom_range(40) == 0) ratio_384 <= ~ratio_384;
		end
	end

	// watchdog well beyond the expected run of about 2200 cycles
	initial begin
		repeat (6000) @(posedge clk_sys);
		n_fail++;
		results();
	end

	// main sequence: every format and width, a cut word, capture disabled
	initial begin
		void'($urandom(41939));
		repeat (3) @(negedge clk_sys);
		resetn = 1'b1;
		@(negedge clk_sys);
		`CHK("format_active", FMT_I2S, format_active)
		enable = 1'b1;
		for (int f = 0; f < 3; f++) begin
			for (int wc = 0; wc < 4; wc++) begin
				half(2'(f), 2'(wc), 32);
				half(2'(f), 2'(wc), 32);
			end
		end
		half(FMT_LJ, WID_24, 10);
		half(FMT_I2S, WID_20, 32);
		enable = 1'b0;
		half(FMT_RJ, WID_16, 32);
		enable = 1'b1;
		repeat (6) half(2'($urandom_range(2)), 2'($urandom_range(3)), 32);
		repeat (2) half(2'h3, WID_18, 32); // spare code 3 behaves as i2s
		repeat (4) @(negedge clk_sys);
		`CHK("notes left", 0, exp_q.size())
		results();
	end
endmodule : sif_formatter_tb_top
`default_nettype wire

// >>> dv/sif_source.sv
// serial audio source: bit clock, frame clock and data for the formatter
// assumes clk_sys is the system clock; pins change at its falling edge
`timescale 1ns/1ns
`default_nettype none
module sif_source (
	input wire logic clk_sys,
	output logic bit_clock,
	output logic frame_clock,
	output logic serial_data
);
	// idle pins low until the first half frame
	initial begin
		bit_clock = 1'b0;
		frame_clock = 1'b0;
		serial_data = 1'b0;
	end

	// one half frame; data and frame move while the bit clock is low
	task automatic send_half(input logic level, input logic [23:0] word, input int d,
		input int w, input int nbits);
		for (int i = 0; i < nbits; i++) begin
			@(negedge clk_sys);
			bit_clock = 1'b0;
			frame_clock = level;
			if (i >= d && i < d + w) begin
				serial_data = word[w - 1 - (i - d)];
			end else begin
				serial_data = ~serial_data; // unused slots toggle so stale bits show
			end
			@(negedge clk_sys);
			bit_clock = 1'b1;
		end
	endtask : send_half
endmodule : sif_source
`default_nettype wire
